/* adcsq_conv_model.sv */
// Converter and analog front end model: answers each start with a result.
// Assumes one-cycle start pulses; the bench sets the conversion latency.
`timescale 1ns/100ps
module adcsq_conv_model
   import adcsq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic conv_start,
   input wire logic [ADCSQ_SRC_W-1:0] conv_src,
   input wire logic conv_diff,
   input wire logic [7:0] lat,
   input wire logic [5:0] pin_digital_function_enable,
   output logic conv_done,
   output logic [ADCSQ_RES_W-1:0] conv_data
);
   logic [7:0] cnt_r = 8'h00;
   logic run_r = 1'b0;
   initial conv_done = 1'b0;
   initial conv_data = 10'h000;
   // Count the latency, then pulse done with a value coded from the source;
   // a single-ended pin still in digital use reads as full scale
   always @(posedge sys_clk) begin
      if (run_r && !conv_start && cnt_r == 8'h00) begin
         run_r <= 1'b0;
         conv_done <= 1'b1;
         if (!conv_diff && conv_src < 3'h6 && pin_digital_function_enable[conv_src]) begin
            conv_data <= 10'h3FF;
         end else begin
            conv_data <= {conv_diff, conv_src, 6'h2A};
         end
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data; // Data is meaningless outside the pulse
         if (conv_start) begin
            run_r <= 1'b1;
            cnt_r <= lat;
         end else if (run_r) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
endmodule

/* adcsq_ctrl.sv */
// Sample sequencer control: four sequencers, arbitration, averaging, result FIFOs.
// Assumes converter returns conv_data with conv_done; config ports are static while enabled.
// Operation
// [R1] Ten-bit results from six analog inputs or the temperature sensor.
// [R2] Four independent sequencers sample several sources without processor help.
// [R3] Programs of one to eight steps; each sequencer owns a result FIFO.
// [R4] Step sources, trigger, interrupts and priority set per sequencer.
// [R5] A triggered sequence runs all its steps back to back.
// [R6] Each step has source, differential mode, interrupt enable, last flag.
// [R7] Optional averaging accumulates up to 64 conversions into one result.
// [R8] Back-to-back steps sustain one million samples per second.
// [R9] Software clears the pin digital enable before analog use.
// [R10] FIFO words are 32 bits with the result in the low 10 bits.
// [R11] Last flag on any step ends the sequence after that step.
// [R12] Priority 0 highest arbitrates simultaneous triggers; values must differ.
// [R13] Finished step with interrupt enabled sets sticky raw status until cleared.
`timescale 1ns/100ps
module adcsq_ctrl
   import adcsq_pkg::*;
#(
   parameter int NSEQ = ADCSQ_NUM_SEQ,
   parameter int NSTEP = ADCSQ_MAX_STEPS,
   parameter int FDEPTH = ADCSQ_FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [NSEQ-1:0] seq_enable,
   input wire logic [NSEQ-1:0] seq_trigger,
   input wire logic [NSEQ*NSTEP*$bits(adcsq_step_t)-1:0] step_cfg,
   input wire logic [NSEQ*ADCSQ_PRI_W-1:0] seq_priority,
   input wire logic [ADCSQ_AVG_SEL_W-1:0] avg_sel,
   input wire logic [NSEQ-1:0] irq_clear,
   output logic [NSEQ-1:0] raw_irq_status,
   output logic [NSEQ-1:0] seq_busy,
   output logic conv_start,
   output logic [ADCSQ_SRC_W-1:0] conv_src,
   output logic conv_diff,
   input wire logic conv_done,
   input wire logic [ADCSQ_RES_W-1:0] conv_data,
   output logic [NSEQ-1:0] fifo_valid,
   input wire logic [NSEQ-1:0] fifo_ready,
   output logic [NSEQ*ADCSQ_WORD_W-1:0] fifo_data
);
   // Averaging counter must reach the largest count, hence one bit over its log
   localparam int AVG_CNT_W = $clog2(ADCSQ_AVG_MAX) + 1;
   // Largest averaging exponent; a larger select clamps the count here
   localparam int AVG_EXP_MAX = $clog2(ADCSQ_AVG_MAX);

   // Whole controller state, registered as one word
   typedef struct packed {
      adcsq_state_t state;
      logic [NSEQ-1:0] pend;
      logic [ADCSQ_SEQ_W-1:0] seq;
      logic [ADCSQ_STEP_W-1:0] step;
      logic [AVG_CNT_W-1:0] avg_cnt;
      logic [ADCSQ_ACC_W-1:0] acc;
      logic [ADCSQ_CNT_W-1:0] pace;
      logic [NSEQ-1:0] irq;
      logic start;
      logic again; // Averaging conversion waiting for its slot
      logic [ADCSQ_SRC_W-1:0] src;
      logic diff;
      adcsq_res_t res;
   } adcsq_ctrl_st_t;
   adcsq_ctrl_st_t st_r, st_nxt;

   // FIFO write handshake, one bit per sequencer
   logic [NSEQ-1:0] push_vld;
   logic [NSEQ-1:0] push_rdy;
   adcsq_step_t cur;

   // Step settings lookup
   function automatic adcsq_step_t step_of(input logic [ADCSQ_SEQ_W-1:0] s,
                                           input logic [ADCSQ_STEP_W-1:0] k);
      step_of = step_cfg[(int'(s)*NSTEP+int'(k))*$bits(adcsq_step_t) +: $bits(adcsq_step_t)];
   endfunction

   // Priority field of one sequencer, 0 being the most urgent
   function automatic logic [ADCSQ_PRI_W-1:0] pri_of(input int s);
      pri_of = seq_priority[s*ADCSQ_PRI_W +: ADCSQ_PRI_W];
   endfunction

   // Settings of the step now converting
   assign cur = step_of(st_r.seq, st_r.step);

   // Drive converter and status outputs from state
   assign conv_start = st_r.start;
   assign conv_src = st_r.src;
   assign conv_diff = st_r.diff;
   assign raw_irq_status = st_r.irq;

   // Next state logic
   always_comb begin
      logic found;
      logic [ADCSQ_PRI_W-1:0] best;
      logic [ADCSQ_SEQ_W-1:0] win;
      logic [ADCSQ_ACC_W-1:0] sum;
      logic [AVG_CNT_W-1:0] need;
      found = 1'b0;
      best = ADCSQ_PRI_LOWEST;
      win = '0;
      sum = ADCSQ_ACC_ZERO;
      need = '0;
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      // Latch triggers of enabled sequencers as pending
      st_nxt.pend = st_r.pend | (seq_trigger & seq_enable); // [R4]
      // Sticky status: set wins over clear
      st_nxt.irq = st_r.irq & ~irq_clear; // [R13]
      // Pacing counter: one conversion slot per microsecond
      if (st_r.pace != '0) begin
         st_nxt.pace = st_r.pace - 1'b1;
      end
      case (st_r.state)
         ADCSQ_IDLE: begin
            // Lowest priority value wins among pending sequencers
            for (int i = 0; i < NSEQ; i++) begin
               if (st_r.pend[i] && seq_enable[i] &&
                   (!found || pri_of(i) < best)) begin // [R12]
                  found = 1'b1;
                  best = pri_of(i);
                  win = ADCSQ_SEQ_W'(i);
               end
            end
            // Start only once the previous conversion's slot has run out
            if (found && st_r.pace == '0) begin // [R2]
               st_nxt.seq = win;
               st_nxt.step = '0;
               st_nxt.acc = ADCSQ_ACC_ZERO;
               st_nxt.avg_cnt = '0;
               st_nxt.start = 1'b1;
               st_nxt.src = step_of(win, '0).src; // [R1]
               st_nxt.diff = step_of(win, '0).diff; // [R6]
               st_nxt.pace = ADCSQ_CNT_W'(ADCSQ_CONV_CYCLES - 1); // [R8]
               st_nxt.state = ADCSQ_CONV;
            end
         end
         ADCSQ_CONV: begin
            if (conv_done) begin
               // Averaging over 2**avg_sel conversions, count clamped at the maximum
               sum = st_r.acc + ADCSQ_ACC_W'(conv_data); // [R7]
               if (avg_sel > ADCSQ_AVG_SEL_W'(AVG_EXP_MAX)) begin
                  need = AVG_CNT_W'(ADCSQ_AVG_MAX);
               end else begin
                  need = AVG_CNT_W'(1) << avg_sel;
               end
               if (st_r.avg_cnt + 1'b1 >= need) begin
                  st_nxt.res.seq = st_r.seq;
                  st_nxt.res.data = ADCSQ_RES_W'(sum >> avg_sel); // [R7]
                  st_nxt.state = ADCSQ_PUSH;
               end else begin
                  // Keep the partial sum; the repeat conversion waits for its slot
                  st_nxt.acc = sum;
                  st_nxt.avg_cnt = st_r.avg_cnt + 1'b1;
                  st_nxt.again = 1'b1;
               end
            end else if (st_r.again && st_r.pace == '0) begin
               // Repeat conversion of the same step, paced like any other
               st_nxt.again = 1'b0;
               st_nxt.start = 1'b1; // [R5]
               st_nxt.pace = ADCSQ_CNT_W'(ADCSQ_CONV_CYCLES - 1); // [R8]
            end
         end
         ADCSQ_PUSH: begin
            // Wait for room in this sequencer's FIFO, then advance
            if (push_rdy[st_r.seq] && st_r.pace == '0) begin
               // Raw status set on the push edge; set wins over a clear
               if (cur.irq_en) begin
                  st_nxt.irq[st_r.seq] = 1'b1; // [R13]
               end
               // Last flag or final slot closes the sequence; re-pend if still triggered
               if (cur.last || st_r.step == ADCSQ_STEP_W'(NSTEP - 1)) begin // [R11]
                  st_nxt.pend[st_r.seq] = seq_trigger[st_r.seq] & seq_enable[st_r.seq];
                  st_nxt.state = ADCSQ_IDLE;
               end else begin
                  // Next step follows without software involvement
                  st_nxt.step = st_r.step + 1'b1; // [R5]
                  st_nxt.acc = ADCSQ_ACC_ZERO;
                  st_nxt.avg_cnt = '0;
                  st_nxt.start = 1'b1;
                  st_nxt.src = step_of(st_r.seq, st_r.step + 1'b1).src;
                  st_nxt.diff = step_of(st_r.seq, st_r.step + 1'b1).diff; // [R6]
                  st_nxt.pace = ADCSQ_CNT_W'(ADCSQ_CONV_CYCLES - 1); // [R8]
                  st_nxt.state = ADCSQ_CONV;
               end
            end
         end
         default: begin
            st_nxt.state = ADCSQ_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // One FIFO per sequencer, result zero-extended into the low bits
   genvar g;
   generate
      for (g = 0; g < NSEQ; g++) begin : g_fifo
         // Push only once the pacing slot has expired
         assign push_vld[g] = (st_r.state == ADCSQ_PUSH) && (st_r.seq == ADCSQ_SEQ_W'(g)) &&
                              (st_r.pace == '0);
         assign seq_busy[g] = (st_r.state != ADCSQ_IDLE) && (st_r.seq == ADCSQ_SEQ_W'(g));
         adcsq_fifo #(.WIDTH(ADCSQ_WORD_W), .DEPTH(FDEPTH)) u_fifo ( // [R3]
            .sys_clk(sys_clk),
            .reset(reset),
            .in_valid(push_vld[g]),
            .in_ready(push_rdy[g]),
            .in_data({{(ADCSQ_WORD_W-ADCSQ_RES_W){1'b0}}, st_r.res.data}), // [R10]
            .out_valid(fifo_valid[g]),
            .out_ready(fifo_ready[g]),
            .out_data(fifo_data[g*ADCSQ_WORD_W +: ADCSQ_WORD_W])
         );
      end
   endgenerate
endmodule

/* adcsq_ctrl_properties.sv */
// Checker of the sequencer control ports: pacing, holding, sticky status.
// Assumes it is bound to adcsq_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module adcsq_ctrl_chk
   import adcsq_pkg::*;
#(
   parameter int NSEQ = ADCSQ_NUM_SEQ
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [NSEQ-1:0] seq_busy,
   input wire logic [NSEQ-1:0] raw_irq_status,
   input wire logic [NSEQ-1:0] irq_clear,
   input wire logic conv_start,
   input wire logic [ADCSQ_SRC_W-1:0] conv_src,
   input wire logic conv_diff,
   input wire logic [NSEQ-1:0] fifo_valid,
   input wire logic [NSEQ-1:0] fifo_ready,
   input wire logic [NSEQ*ADCSQ_WORD_W-1:0] fifo_data
);
   logic [7:0] gap_r;
   logic [7:0] gap_nxt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Cycles since the last start, saturating so the first start is free
   always_comb begin
      gap_nxt = (gap_r == 8'hff) ? gap_r : gap_r + 8'h01;
      if (conv_start) gap_nxt = 8'h00;
   end
   always_ff @(posedge sys_clk) begin
      gap_r <= reset ? 8'hff : gap_nxt;
   end
   // Port relations
   chk_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("start wider than one cycle");
   chk_start_gap: assert property (conv_start |-> gap_r >= 8'h63)
      else $error("starts closer than one microsecond");
   chk_start_busy: assert property (conv_start |-> $onehot(seq_busy))
      else $error("start without one busy sequencer");
   chk_busy_one: assert property ($onehot0(seq_busy))
      else $error("two sequencers busy");
   chk_cfg_hold: assert property ($changed({conv_src, conv_diff}) |-> conv_start)
      else $error("source changed between starts");
   chk_irq_sticky: assert property (
      (~raw_irq_status & $past(raw_irq_status) & ~$past(irq_clear)) == '0)
      else $error("status fell without clear");
   chk_irq_cause: assert property (
      (raw_irq_status & ~$past(raw_irq_status) & ~$past(seq_busy)) == '0)
      else $error("status set by idle sequencer");
   chk_fifo_hold: assert property (
      fifo_valid[NSEQ-1] && !fifo_ready[NSEQ-1] |=>
      fifo_valid[NSEQ-1] && $stable(fifo_data[NSEQ*ADCSQ_WORD_W-1 -: ADCSQ_WORD_W]))
      else $error("stalled head not held");
   cov_diff: cover property (conv_start && conv_diff);
   cov_irq: cover property ($rose(raw_irq_status[0]));
   cov_stall: cover property (fifo_valid[NSEQ-1] && !fifo_ready[NSEQ-1] && seq_busy[NSEQ-1]);
endmodule
bind adcsq_ctrl adcsq_ctrl_chk #(.NSEQ(NSEQ)) i_chk (.sys_clk(sys_clk), .reset(reset),
   .seq_busy(seq_busy), .raw_irq_status(raw_irq_status), .irq_clear(irq_clear),
   .conv_start(conv_start), .conv_src(conv_src), .conv_diff(conv_diff),
   .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_data(fifo_data));

/* adcsq_fifo.sv */
// Result FIFO with valid/ready on both sides, width and depth as parameters.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/100ps
module adcsq_fifo
   import adcsq_pkg::*;
#(
   parameter int WIDTH = ADCSQ_WORD_W,
   parameter int DEPTH = ADCSQ_FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } adcsq_fifo_st_t;
   adcsq_fifo_st_t st_r, st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // Handshake flags
   assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[st_r.rp];

   // Pointer and count update
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register and storage
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
      if (push) begin
         mem[st_r.wp] <= in_data;
      end
   end
endmodule

/* adcsq_pkg.sv */
// Package for the sample sequencer control block: constants, types, states.
// Assumes a single 100 MHz clock domain and plain configuration ports.
package adcsq_pkg;
   localparam int ADCSQ_RES_W = 10;
   localparam int ADCSQ_NUM_SEQ = 4;
   localparam int ADCSQ_MAX_STEPS = 8;
   localparam int ADCSQ_STEP_W = 3;
   localparam int ADCSQ_SRC_W = 3;
   localparam int ADCSQ_WORD_W = 32;
   localparam int ADCSQ_FIFO_DEPTH = 32;
   localparam int ADCSQ_PRI_W = 2;
   localparam int ADCSQ_AVG_MAX = 64;
   localparam int ADCSQ_AVG_SEL_W = 3;
   localparam int ADCSQ_ACC_W = 16;
   localparam int ADCSQ_SEQ_W = 2;
   // Throughput: one conversion per microsecond
   localparam int ADCSQ_CLK_MHZ = 100;
   localparam int ADCSQ_SAMPLE_RATE_KSPS = 1000;
   localparam int ADCSQ_CONV_CYCLES = (ADCSQ_CLK_MHZ * 1000) / ADCSQ_SAMPLE_RATE_KSPS;
   localparam int ADCSQ_CNT_W = 8;
   localparam logic [ADCSQ_SRC_W-1:0] ADCSQ_SRC_TEMP = 3'h6;
   localparam logic [ADCSQ_ACC_W-1:0] ADCSQ_ACC_ZERO = 16'h0000;
   localparam logic [ADCSQ_PRI_W-1:0] ADCSQ_PRI_LOWEST = 2'h3;

   // Per-step settings of one sequencer step
   typedef struct packed {
      logic [ADCSQ_SRC_W-1:0] src;
      logic diff;
      logic irq_en;
      logic last;
   } adcsq_step_t;

   // Result as handed to the FIFO
   typedef struct packed {
      logic [ADCSQ_SEQ_W-1:0] seq;
      logic [ADCSQ_RES_W-1:0] data;
   } adcsq_res_t;

   typedef enum logic [1:0] {
      ADCSQ_IDLE = 2'b00,
      ADCSQ_CONV = 2'b01,
      ADCSQ_PUSH = 2'b11
   } adcsq_state_t;
endpackage

/* tb.sv */
// Self-checking bench of the sequencer control with the converter model.
// Assumes one 100 MHz clock and inputs driven at the falling edge.
`timescale 1ns/100ps
module tb;
   import adcsq_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] seq_enable, seq_trigger, irq_clear, raw_irq_status, seq_busy, fifo_valid;
   logic [3:0] fifo_ready;
   logic [191:0] step_cfg;
   logic [7:0] seq_priority, lat;
   logic [2:0] avg_sel, conv_src;
   logic conv_start, conv_diff, conv_done;
   logic [9:0] conv_data;
   logic [127:0] fifo_data;
   logic [5:0] pin_digital_function_enable;
   int miscompares = 0;
   int checks_done = 0;
   int n_starts = 0;
   logic [2:0] src_q[$];
   adcsq_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .seq_enable(seq_enable),
      .seq_trigger(seq_trigger), .step_cfg(step_cfg), .seq_priority(seq_priority),
      .avg_sel(avg_sel), .irq_clear(irq_clear), .raw_irq_status(raw_irq_status),
      .seq_busy(seq_busy), .conv_start(conv_start), .conv_src(conv_src),
      .conv_diff(conv_diff), .conv_done(conv_done), .conv_data(conv_data),
      .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_data(fifo_data));
   adcsq_conv_model i_conv (.sys_clk(sys_clk), .conv_start(conv_start), .conv_src(conv_src),
      .conv_diff(conv_diff), .lat(lat),
      .pin_digital_function_enable(pin_digital_function_enable),
      .conv_done(conv_done), .conv_data(conv_data));
   initial forever #5 sys_clk = ~sys_clk;
   // Log every conversion start and its source
   always @(posedge sys_clk) begin
      if (!reset && conv_start === 1'b1) begin
         n_starts++;
         src_q.push_back(conv_src);
      end
   end
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [9:0] ev(input logic [2:0] src, input logic d);
      return {d, src, 6'h2A};
   endfunction
   task automatic step(input int s, input int k, input logic [5:0] v);
      step_cfg[(s*8+k)*6 +: 6] = v;
   endtask
   task automatic pulse(input logic [3:0] m);
      @(negedge sys_clk) seq_trigger = m;
      @(negedge sys_clk) seq_trigger = 4'h0;
   endtask
   // Trigger, then wait until every chosen sequencer has results and is idle
   task automatic go(input logic [3:0] m);
      pulse(m);
      repeat (3) @(negedge sys_clk);
      for (int i = 0; i < 9000 && ((fifo_valid & m) !== m || (seq_busy & m) !== 4'h0); i++)
         @(negedge sys_clk);
      check(10'(seq_busy & m), 10'h000);
   endtask
   // Take one word; a clock edge passes before the next request
   task automatic pop(input int s, input logic [9:0] exp);
      for (int i = 0; i < 200 && fifo_valid[s] !== 1'b1; i++) @(negedge sys_clk);
      check(10'(fifo_valid[s]), 10'h001);
      check(fifo_data[s*32 +: 10], exp);
      fifo_ready[s] = 1'b1;
      @(negedge sys_clk) fifo_ready[s] = 1'b0;
      @(negedge sys_clk);
   endtask
   // Five-step program ending early, with an interrupt on step one
   task automatic t_seq();
      int q0;
      for (int k = 0; k < 8; k++) step(0, k, {3'(k % 7), k == 2, k == 1, k == 4});
      q0 = src_q.size();
      go(4'h1);
      check(10'(src_q.size() - q0), 10'h005);
      for (int k = 0; k < 5; k++) check(10'(src_q[q0 + k]), 10'(k));
      for (int k = 0; k < 5; k++) pop(0, ev(3'(k), k == 2));
      check(10'(fifo_valid[0]), 10'h000);
      repeat (20) @(negedge sys_clk);
      check(10'(raw_irq_status), 10'h001);
      irq_clear = 4'h1;
      @(negedge sys_clk) irq_clear = 4'h0;
      @(negedge sys_clk) check(10'(raw_irq_status), 10'h000);
   endtask
   // Two sequencers triggered together under two priority maps, slow converter
   task automatic t_pri();
      logic [7:0] pm[2] = '{8'h8D, 8'hD2};
      int q0;
      lat = 8'hC8;
      step(1, 0, 6'h31); // Temperature sensor, last
      step(2, 0, 6'h29); // Input five, last
      for (int i = 0; i < 2; i++) begin
         seq_priority = pm[i];
         q0 = src_q.size();
         go(4'h6);
         check(10'(src_q[q0]), i ? 10'h006 : 10'h005);
         pop(1, ev(3'h6, 1'b0));
         pop(2, ev(3'h5, 1'b0));
      end
      lat = 8'h05;
   endtask
   // Disabled trigger refused, then FIFO filled past full and drained
   task automatic t_fill();
      int n0;
      n0 = n_starts;
      seq_enable = 4'h7;
      pulse(4'h8);
      repeat (10) @(negedge sys_clk);
      check(10'(n_starts - n0), 10'h000);
      seq_enable = 4'hF;
      step(3, 0, 6'h21); // Input four, last
      for (int i = 0; i < 32; i++) go(4'h8);
      pulse(4'h8);
      repeat (300) @(negedge sys_clk);
      check(10'(seq_busy[3]), 10'h001);
      for (int i = 0; i < 33; i++) pop(3, ev(3'h4, 1'b0));
      check(10'(fifo_valid[3]), 10'h000);
   endtask
   // Averaging over one to sixty-four conversions; select 7 clamps the count
   task automatic t_avg();
      int n0;
      step(0, 0, 6'h1D); // Input three, differential, last
      for (int a = 0; a < 8; a++) begin
         avg_sel = 3'(a);
         n0 = n_starts;
         go(4'h1);
         check(10'(n_starts - n0), 10'(a == 7 ? ADCSQ_AVG_MAX : 1 << a));
         pop(0, ev(3'h3, 1'b1) >> (a == 7));
      end
      avg_sel = 3'h0;
   endtask
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Cut a hang short well beyond the expected run length
   initial begin
      #600000;
      miscompares++;
      finish_test();
   end
   // Reset, then the scenarios in turn
   initial begin
      seq_enable = 4'hF;
      seq_trigger = 4'h0;
      step_cfg = '0;
      seq_priority = 8'h8D;
      avg_sel = 3'h0;
      irq_clear = 4'h0;
      fifo_ready = 4'h0;
      lat = 8'h05;
      pin_digital_function_enable = 6'h3F; // Pins come up in digital use
      repeat (10) @(negedge sys_clk);
      pin_digital_function_enable = 6'h00;
      reset = 1'b0;
      t_seq();
      t_pri();
      t_fill();
      t_avg();
      finish_test();
   end
endmodule
